// >>> rtl/xfer_exec_map.vh
// Constants for the transfer, test and software-trap execution unit.
// Included by the execution unit, its checker and its bench; definitions only.
`ifndef XFER_EXEC_MAP_VH
`define XFER_EXEC_MAP_VH

`define OPC_SOFT_TRAP 8'h83
`define OPC_ACC_TO_FLAGS 8'h84
`define OPC_FLAGS_TO_ACC 8'h85
`define OPC_STACK_TO_INDEX 8'h95
`define OPC_INDEX_TO_STACK 8'h94
`define OPC_ACC_TO_INDEXLOW 8'h97
`define OPC_INDEXLOW_TO_ACC 8'h9f
`define OPC_CHECK_DIRECT 8'h3d
`define OPC_CHECK_ACC 8'h4d
`define OPC_CHECK_INDEXLOW 8'h5d
`define OPC_CHECK_OFFSET8 8'h6d
`define OPC_CHECK_NOOFFSET 8'h7d
`define OPC_PREFIX 8'h9e

`define CYC_SOFT_TRAP 4'h9
`define CYC_ACC_TO_FLAGS 4'h2
`define CYC_FLAGS_TO_ACC 4'h1
`define CYC_STACK_INDEX 4'h2
`define CYC_INDEXLOW_XFER 4'h1
`define CYC_CHECK_DIRECT 4'h3
`define CYC_CHECK_REG 4'h1
`define CYC_CHECK_OFFSET8 4'h3
`define CYC_CHECK_NOOFFSET 4'h2
`define CYC_CHECK_STACK8 4'h4

`define FLAG_V 7
`define FLAG_H 4
`define FLAG_I 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0

`define RST_FLAGS 8'h68
`define RST_STACK 16'h00ff
`define RST_PROGCTR 16'h0000
`define TRAP_VECTOR 16'hfffc

`endif

// >>> rtl/xfer_exec_mem.v
// Small byte memory standing in for the core's data space.
// One write port and one read port; read data is registered.
`timescale 1ns/1ns
`default_nettype none
module xfer_exec_mem #(
    parameter ADDR_W = 8
) (
    input wire clk_sys, // Core clock
    input wire wr_en, // Write strobe
    input wire [ADDR_W-1:0] wr_addr, // Write address
    input wire [7:0] wr_data, // Write byte
    input wire [ADDR_W-1:0] rd_addr, // Read address
    output reg [7:0] rd_data // Registered read byte
);
    reg [7:0] mem [0:(1<<ADDR_W)-1];

    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // xfer_exec_mem
`default_nettype wire

// >>> rtl/xfer_exec.v
// Execution unit for the trap, transfer and zero/negative check opcodes.
// Assumes one opcode (plus prefix/offset bytes) is handed in per start
// pulse; the low memory page is modelled by xfer_exec_mem.
// A start is decoded only from idle, so one during execution is dropped.
// done rises N+1 edges after the take edge, N being the opcode's count;
// every register and memory effect has landed by then.
`timescale 1ns/1ns
`default_nettype none
`include "xfer_exec_map.vh"
module xfer_exec #(
    parameter ADDR_W = 8
) (
    input wire clk_sys, // Core clock, 25 MHz
    input wire resetn, // Synchronous reset, active low
    input wire start, // Pulse: opcode bytes valid
    input wire [7:0] opcode, // Opcode byte
    input wire prefixed, // Opcode preceded by prefix byte
    input wire [7:0] operand, // Direct address or offset byte
    input wire [15:0] trap_vector, // Interrupt vector bytes
    output reg busy, // Instruction in progress
    output reg done, // Pulse: effects complete, fetch next
    output reg illegal, // Pulse: opcode not handled here
    output reg [7:0] acc, // Accumulator
    output reg [15:0] index, // H:X index
    output reg [15:0] stack, // Stack pointer
    output reg [15:0] progctr, // Program counter
    output reg [7:0] flags_register // V 1 1 H I N Z C
);
    localparam S_IDLE = 2'd0;
    localparam S_RUN = 2'd1;
    localparam S_DONE = 2'd2;

    localparam K_NONE = 3'd0;
    localparam K_TRAP = 3'd1;
    localparam K_A2F = 3'd2;
    localparam K_F2A = 3'd3;
    localparam K_S2X = 3'd4;
    localparam K_X2S = 3'd5;
    localparam K_A2X = 3'd6;
    localparam K_X2A = 3'd7;

    // Trap sequence steps, counted by cyc_reg from 1
    localparam T_BUMP = 4'h1;
    localparam T_PUSH_PCL = 4'h2;
    localparam T_PUSH_PCH = 4'h3;
    localparam T_PUSH_X = 4'h4;
    localparam T_PUSH_A = 4'h5;
    localparam T_PUSH_FLAGS = 4'h6;
    localparam T_VEC_HIGH = 4'h7;
    localparam T_VEC_LOW = 4'h8;

    reg [1:0] state_reg;
    reg [2:0] kind_reg;
    reg check_reg;
    reg [3:0] cyc_reg;
    reg [3:0] len_reg;
    reg [ADDR_W-1:0] ea_reg;
    reg mem_op_reg;
    reg wr_en;
    reg [ADDR_W-1:0] wr_addr;
    reg [7:0] wr_data;
    wire [7:0] rd_data;

    // Flags after a zero/negative check of a byte
    function [7:0] check_flags;
        input [7:0] f;
        input [7:0] v;
        begin
            check_flags = f;
            check_flags[`FLAG_V] = 1'b0;
            check_flags[`FLAG_N] = v[7];
            check_flags[`FLAG_Z] = (v == 8'h00);
        end
    endfunction

    // Low-page operand address: base register plus offset byte
    function [ADDR_W-1:0] off_addr;
        input [15:0] base;
        input [7:0] off;
        begin
            off_addr = base[ADDR_W-1:0] + off[ADDR_W-1:0];
        end
    endfunction

    // Pushes and operand reads share one little memory
    xfer_exec_mem #(.ADDR_W(ADDR_W)) u_mem (
        .clk_sys(clk_sys),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(ea_reg),
        .rd_data(rd_data)
    );

    // Decode and launch
    always @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg <= S_IDLE;
            kind_reg <= K_NONE;
            check_reg <= 1'b0;
            cyc_reg <= 4'h0;
            len_reg <= 4'h0;
            ea_reg <= {ADDR_W{1'b0}};
            mem_op_reg <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= {ADDR_W{1'b0}};
            wr_data <= 8'h00;
            // Stack and flags reset values are this core's own choice
            busy <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
            acc <= 8'h00;
            index <= 16'h0000;
            stack <= `RST_STACK;
            progctr <= `RST_PROGCTR;
            flags_register <= `RST_FLAGS;
        end else begin
            done <= 1'b0;
            illegal <= 1'b0;
            wr_en <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        cyc_reg <= 4'h1;
                        // Clearing check and memory flags keeps old forms out
                        check_reg <= 1'b0;
                        mem_op_reg <= 1'b0;
                        kind_reg <= K_NONE;
                        state_reg <= S_RUN;
                        // Only the zero/negative check has a stack form here
                        if (prefixed) begin
                            if (opcode == `OPC_CHECK_OFFSET8) begin
                                check_reg <= 1'b1;
                                mem_op_reg <= 1'b1;
                                len_reg <= `CYC_CHECK_STACK8;
                                ea_reg <= off_addr(stack, operand);
                            end else begin
                                illegal <= 1'b1;
                                busy <= 1'b0;
                                state_reg <= S_IDLE;
                            end
                        end else begin
                            case (opcode)
                                `OPC_SOFT_TRAP: begin
                                    kind_reg <= K_TRAP;
                                    len_reg <= `CYC_SOFT_TRAP;
                                end
                                `OPC_ACC_TO_FLAGS: begin
                                    kind_reg <= K_A2F;
                                    len_reg <= `CYC_ACC_TO_FLAGS;
                                end
                                `OPC_FLAGS_TO_ACC: begin
                                    kind_reg <= K_F2A;
                                    len_reg <= `CYC_FLAGS_TO_ACC;
                                end
                                `OPC_STACK_TO_INDEX: begin
                                    kind_reg <= K_S2X;
                                    len_reg <= `CYC_STACK_INDEX;
                                end
                                `OPC_INDEX_TO_STACK: begin
                                    kind_reg <= K_X2S;
                                    len_reg <= `CYC_STACK_INDEX;
                                end
                                `OPC_ACC_TO_INDEXLOW: begin
                                    kind_reg <= K_A2X;
                                    len_reg <= `CYC_INDEXLOW_XFER;
                                end
                                `OPC_INDEXLOW_TO_ACC: begin
                                    kind_reg <= K_X2A;
                                    len_reg <= `CYC_INDEXLOW_XFER;
                                end
                                `OPC_CHECK_DIRECT: begin
                                    check_reg <= 1'b1;
                                    mem_op_reg <= 1'b1;
                                    len_reg <= `CYC_CHECK_DIRECT;
                                    ea_reg <= operand[ADDR_W-1:0];
                                end
                                `OPC_CHECK_ACC: begin
                                    check_reg <= 1'b1;
                                    kind_reg <= K_A2X;
                                    len_reg <= `CYC_CHECK_REG;
                                end
                                `OPC_CHECK_INDEXLOW: begin
                                    check_reg <= 1'b1;
                                    kind_reg <= K_X2A;
                                    len_reg <= `CYC_CHECK_REG;
                                end
                                `OPC_CHECK_OFFSET8: begin
                                    check_reg <= 1'b1;
                                    mem_op_reg <= 1'b1;
                                    len_reg <= `CYC_CHECK_OFFSET8;
                                    ea_reg <= off_addr(index,
                                        operand);
                                end
                                `OPC_CHECK_NOOFFSET: begin
                                    check_reg <= 1'b1;
                                    mem_op_reg <= 1'b1;
                                    len_reg <= `CYC_CHECK_NOOFFSET;
                                    ea_reg <= index[ADDR_W-1:0];
                                end
                                default: begin
                                    illegal <= 1'b1;
                                    busy <= 1'b0;
                                    state_reg <= S_IDLE;
                                end
                            endcase
                        end
                    end
                end
                S_RUN: begin
                    cyc_reg <= cyc_reg + 4'h1;
                    if (kind_reg == K_TRAP && !check_reg) begin
                        // Pushes happen in cycles 2..6; SP moves after each
                        case (cyc_reg)
                            T_BUMP: progctr <= progctr + 16'h0001;
                            T_PUSH_PCL: begin
                                wr_en <= 1'b1;
                                wr_addr <= stack[ADDR_W-1:0];
                                wr_data <= progctr[7:0];
                                stack <= stack - 16'h0001;
                            end
                            T_PUSH_PCH: begin
                                wr_en <= 1'b1;
                                wr_addr <= stack[ADDR_W-1:0];
                                wr_data <= progctr[15:8];
                                stack <= stack - 16'h0001;
                            end
                            T_PUSH_X: begin
                                wr_en <= 1'b1;
                                wr_addr <= stack[ADDR_W-1:0];
                                wr_data <= index[7:0];
                                stack <= stack - 16'h0001;
                            end
                            T_PUSH_A: begin
                                wr_en <= 1'b1;
                                wr_addr <= stack[ADDR_W-1:0];
                                wr_data <= acc;
                                stack <= stack - 16'h0001;
                            end
                            // Old flags go out; the mask is set on the same edge
                            T_PUSH_FLAGS: begin
                                wr_en <= 1'b1;
                                wr_addr <= stack[ADDR_W-1:0];
                                wr_data <= flags_register;
                                stack <= stack - 16'h0001;
                                flags_register[`FLAG_I] <= 1'b1;
                            end
                            // Vector is taken a byte per cycle, high first
                            T_VEC_HIGH: begin
                                progctr[15:8] <= trap_vector[15:8];
                            end
                            T_VEC_LOW: begin
                                progctr[7:0] <= trap_vector[7:0];
                            end
                            default: ;
                        endcase
                    end
                    // Memory forms use rd_data registered from ea_reg
                    if (cyc_reg == len_reg) begin
                        state_reg <= S_DONE;
                        if (check_reg && mem_op_reg) begin
                            flags_register <= check_flags(flags_register,
                                rd_data);
                        end else if (check_reg && kind_reg == K_A2X) begin
                            flags_register <= check_flags(flags_register,
                                acc);
                        end else if (check_reg) begin
                            flags_register <= check_flags(flags_register,
                                index[7:0]);
                        end else begin
                            // Bits 6:5 of the flags always read as one
                            case (kind_reg)
                                K_A2F: flags_register <= acc | 8'h60;
                                K_F2A: acc <= flags_register;
                                K_S2X: index <= stack + 16'h0001;
                                K_X2S: stack <= index - 16'h0001;
                                K_A2X: index[7:0] <= acc;
                                K_X2A: acc <= index[7:0];
                                default: ;
                            endcase
                        end
                    end
                end
                S_DONE: begin
                    // Memory writes have landed; next opcode may start
                    busy <= 1'b0;
                    done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // xfer_exec
`default_nettype wire

// >>> testbench/xfer_exec_checker.sv
// Checker for xfer_exec: cycle counts and register effects per opcode.
// Sees only the unit's ports; bound to it at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
`include "xfer_exec_map.vh"
module xfer_exec_checker #(
    parameter ADDR_W = 8
) (
    input wire logic clk_sys, // Core clock
    input wire logic resetn, // Sync reset, active low
    input wire logic start, // Request pulse
    input wire logic [7:0] opcode, // Opcode byte
    input wire logic prefixed, // Prefix seen
    input wire logic [7:0] operand, // Offset or address
    input wire logic [15:0] trap_vector, // Vector bytes
    input wire logic busy, // Executing
    input wire logic done, // Completion pulse
    input wire logic illegal, // Unknown opcode pulse
    input wire logic [7:0] acc, // Accumulator
    input wire logic [15:0] index, // Index pair
    input wire logic [15:0] stack, // Stack pointer
    input wire logic [15:0] progctr, // Program counter
    input wire logic [7:0] flags_register // Flags
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    logic go;
    // Starts while busy are refused, so they never open a check
    assign go = start && !busy && !prefixed;
    chk_trap_length: assert property (go && opcode == `OPC_SOFT_TRAP
        |-> ##1 (busy && !done) [*8] ##3 done)
        else $error("trap length wrong");
    chk_trap_stack: assert property (go && opcode == `OPC_SOFT_TRAP
        |-> ##11 stack == $past(stack, 11) - 16'h0005)
        else $error("trap stack depth wrong");
    chk_trap_mask: assert property (go && opcode == `OPC_SOFT_TRAP
        |-> ##11 flags_register == ($past(flags_register, 11) | 8'h08))
        else $error("trap mask wrong");
    chk_flags_to_acc: assert property (go && opcode == `OPC_FLAGS_TO_ACC
        |-> ##3 done && acc == $past(flags_register, 3)
        && flags_register == $past(flags_register, 3))
        else $error("flags to acc wrong");
    chk_acc_to_flags: assert property (go && opcode == `OPC_ACC_TO_FLAGS
        |-> ##1 !done ##3 done && flags_register == ($past(acc, 4) | 8'h60))
        else $error("acc to flags wrong");
    chk_check_acc: assert property (go && opcode == `OPC_CHECK_ACC
        |-> ##3 done && flags_register == {1'b0, $past(flags_register[6:3], 3),
        $past(acc[7], 3), $past(acc, 3) == 8'h00, $past(flags_register[0], 3)})
        else $error("acc check flags wrong");
    chk_acc_to_xlow: assert property (go && opcode == `OPC_ACC_TO_INDEXLOW
        |-> ##3 done && index == {$past(index[15:8], 3), $past(acc, 3)})
        else $error("acc to index low wrong");
    chk_stack_index: assert property (go && opcode == `OPC_STACK_TO_INDEX
        |-> ##4 done && index == $past(stack, 4) + 16'h0001)
        else $error("stack to index wrong");
    chk_index_stack: assert property (go && opcode == `OPC_INDEX_TO_STACK
        |-> ##4 done && stack == $past(index, 4) - 16'h0001)
        else $error("index to stack wrong");
    chk_stack8_length: assert property (start && !busy && prefixed
        && opcode == `OPC_CHECK_OFFSET8 |-> ##5 !done ##1 done)
        else $error("stack offset length wrong");
    cover property (go && opcode == `OPC_SOFT_TRAP);
    cover property (illegal);
    cover property (start && !busy && prefixed);
endmodule // xfer_exec_checker
bind xfer_exec xfer_exec_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .start(start), .opcode(opcode),
    .prefixed(prefixed), .operand(operand), .trap_vector(trap_vector),
    .busy(busy), .done(done), .illegal(illegal), .acc(acc), .index(index),
    .stack(stack), .progctr(progctr), .flags_register(flags_register)
);
`default_nettype wire

// >>> testbench/xfer_exec_tb_top.sv
// Bench for xfer_exec: runs each opcode through start/done and judges
// the registers; memory is read only where the trap has stacked bytes.
`timescale 1ns/1ns
`default_nettype none
`include "xfer_exec_map.vh"
module xfer_exec_tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic prefixed = 1'b0;
    logic [7:0] operand = 8'h00;
    logic [15:0] trap_vector = 16'h1234;
    wire busy;
    wire done;
    wire illegal;
    wire [7:0] acc;
    wire [15:0] index;
    wire [15:0] stack;
    wire [15:0] progctr;
    wire [7:0] flags_register;
    int num_errors = 0;
    int checks_done = 0;

    always #20 clk_sys = ~clk_sys;

    xfer_exec #(.ADDR_W(8)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .start(start),
        .opcode(opcode), .prefixed(prefixed), .operand(operand),
        .trap_vector(trap_vector), .busy(busy), .done(done),
        .illegal(illegal), .acc(acc), .index(index), .stack(stack),
        .progctr(progctr), .flags_register(flags_register)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic regs(input logic [7:0] a, input logic [15:0] x,
            input logic [15:0] s, input logic [7:0] f);
        check({8'h00, acc}, {8'h00, a});
        check(index, x);
        check(stack, s);
        check({8'h00, flags_register}, {8'h00, f});
    endtask

    // One start pulse; refuse repeats start mid-run, which must be ignored
    task automatic run(input logic [7:0] op, input logic pfx,
            input logic [7:0] opr, input int edges, input logic bad,
            input logic refuse);
        int k;
        @(negedge clk_sys);
        start = 1'b1;
        opcode = op;
        prefixed = pfx;
        operand = opr;
        @(negedge clk_sys);
        start = 1'b0;
        // The take edge counts as the first
        k = 1;
        while (done !== 1'b1 && illegal !== 1'b1 && k < 40) begin
            @(negedge clk_sys);
            k++;
            start = refuse && k == 3;
        end
        start = 1'b0;
        check(16'(k), 16'(edges));
        check({15'h0000, illegal}, {15'h0000, bad});
    endtask

    task automatic t_reset_state();
        regs(8'h00, 16'h0000, 16'h00ff, 8'h68);
        check(progctr, 16'h0000);
    endtask

    task automatic t_moves();
        run(`OPC_INDEX_TO_STACK, 1'b0, 8'h00, 4, 1'b0, 1'b0);
        regs(8'h00, 16'h0000, 16'hffff, 8'h68);
        run(`OPC_ACC_TO_FLAGS, 1'b0, 8'h00, 4, 1'b0, 1'b0);
        regs(8'h00, 16'h0000, 16'hffff, 8'h60);
        run(`OPC_FLAGS_TO_ACC, 1'b0, 8'h00, 3, 1'b0, 1'b0);
        regs(8'h60, 16'h0000, 16'hffff, 8'h60);
        run(`OPC_ACC_TO_INDEXLOW, 1'b0, 8'h00, 3, 1'b0, 1'b0);
        regs(8'h60, 16'h0060, 16'hffff, 8'h60);
    endtask

    task automatic t_trap();
        run(`OPC_SOFT_TRAP, 1'b0, 8'h00, 11, 1'b0, 1'b1);
        regs(8'h60, 16'h0060, 16'hfffa, 8'h68);
        check(progctr, 16'h1234);
    endtask

    // Stacked bytes: ff=PC low 01, fe=PC high 00, fb=flags 60
    task automatic t_memory_forms();
        run(`OPC_CHECK_DIRECT, 1'b0, 8'hfe, 5, 1'b0, 1'b0);
        check({8'h00, flags_register}, 16'h006a);
        run(`OPC_STACK_TO_INDEX, 1'b0, 8'h00, 4, 1'b0, 1'b0);
        regs(8'h60, 16'hfffb, 16'hfffa, 8'h6a);
        run(`OPC_CHECK_NOOFFSET, 1'b0, 8'h00, 4, 1'b0, 1'b0);
        check({8'h00, flags_register}, 16'h0068);
        run(`OPC_CHECK_OFFSET8, 1'b0, 8'h03, 5, 1'b0, 1'b0);
        check({8'h00, flags_register}, 16'h006a);
        run(`OPC_CHECK_OFFSET8, 1'b1, 8'h05, 6, 1'b0, 1'b0);
        check({8'h00, flags_register}, 16'h0068);
    endtask

    task automatic t_register_forms();
        run(`OPC_INDEXLOW_TO_ACC, 1'b0, 8'h00, 3, 1'b0, 1'b0);
        regs(8'hfb, 16'hfffb, 16'hfffa, 8'h68);
        run(`OPC_ACC_TO_FLAGS, 1'b0, 8'h00, 4, 1'b0, 1'b0);
        check({8'h00, flags_register}, 16'h00fb);
        run(`OPC_CHECK_ACC, 1'b0, 8'h00, 3, 1'b0, 1'b0);
        check({8'h00, flags_register}, 16'h007d);
        run(`OPC_ACC_TO_FLAGS, 1'b0, 8'h00, 4, 1'b0, 1'b0);
        run(`OPC_CHECK_INDEXLOW, 1'b0, 8'h00, 3, 1'b0, 1'b0);
        check({8'h00, flags_register}, 16'h007d);
        run(`OPC_FLAGS_TO_ACC, 1'b0, 8'h00, 3, 1'b0, 1'b0);
        run(`OPC_ACC_TO_INDEXLOW, 1'b0, 8'h00, 3, 1'b0, 1'b0);
        regs(8'h7d, 16'hff7d, 16'hfffa, 8'h7d);
    endtask

    task automatic t_illegal();
        run(8'h00, 1'b0, 8'h00, 1, 1'b1, 1'b0);
        run(`OPC_CHECK_DIRECT, 1'b1, 8'hfe, 1, 1'b1, 1'b0);
        regs(8'h7d, 16'hff7d, 16'hfffa, 8'h7d);
    endtask

    task automatic finish_test();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        t_reset_state();
        t_moves();
        t_trap();
        t_memory_forms();
        t_register_forms();
        t_illegal();
        finish_test();
    end

    // About 115 cycles of work; far beyond that means a hang
    initial begin
        #(40 * 2000);
        num_errors++;
        finish_test();
    end
endmodule // xfer_exec_tb_top
`default_nettype wire
